// File: src/quadrature_counter_homing_pkg.sv
// constants and types shared by the quadrature counter with homing
package quadrature_counter_homing_pkg;
  // register offsets, as printed
  localparam logic [15:0] OFS_SUPPLY = 16'h0028;
  localparam logic [15:0] OFS_INLEV = 16'h0108;
  localparam logic [15:0] OFS_EDGE_WORD = 16'h0200;
  localparam logic [15:0] OFS_REF_SWITCH = 16'h0208;
  localparam logic [15:0] OFS_REF_LEVEL = 16'h020A;
  localparam logic [15:0] OFS_PRESET_1 = 16'h0810;
  localparam logic [15:0] OFS_PRESET_2 = 16'h0814;
  localparam logic [15:0] OFS_COUNT = 16'h0820;
  localparam logic [15:0] OFS_MODE = 16'h0844;
  localparam logic [15:0] OFS_STATUS = 16'h0846;
  localparam logic [15:0] OFS_FALL_CODE = 16'h1008;
  localparam logic [15:0] OFS_RISE_CODE = 16'h100A;
  // function models
  localparam logic [7:0] FM_STD = 8'h00;
  localparam logic [7:0] FM_STD32 = 8'h01;
  localparam logic [7:0] FM_MOTION = 8'h02;
  localparam logic [7:0] FM_BUSCTL = 8'hFE;
  // edge selection codes and reset values
  localparam logic [7:0] CODE_SEL = 8'h04;
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [15:0] EDGE_WORD_RISE = 16'h1012;
  localparam logic [15:0] EDGE_WORD_FALL = 16'h1002;
  localparam logic [7:0] REF_ON = 8'h08;
  localparam logic [7:0] REF_OFF = 8'h00;
  // homing mode codes
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_SINGLE = 8'hC1;
  localparam logic [7:0] MODE_CONT = 8'hC3;
  // homing status bit positions
  localparam int ST_HOMED = 2;
  localparam int ST_TOGGLE = 3;
  localparam int ST_REFSEEN = 4;
  localparam int ST_CNT_LO = 5;
  // synchronised input vector positions
  localparam int IN_A = 0;
  localparam int IN_B = 1;
  localparam int IN_R = 2;
  localparam int IN_AUX = 3;
  localparam int IN_SUP = 4;
  localparam int IN_W = 5;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_ARMED = 3'b010,
    HS_DONE = 3'b100
  } home_state_t;

  // cyclic object, byte 0 lowest
  typedef struct packed {
    logic [7:0] homing_status;
    logic [7:0] supply_status;
    logic [7:0] input_levels;
    logic [15:0] position_count;
  } cyc_obj_t;
endpackage : quadrature_counter_homing_pkg

// File: src/quadrature_counter_homing.sv
// quadrature counter with index homing, status and register access
`timescale 1ns/1ns
`default_nettype none
module quadrature_counter_homing (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // encoder and field pins, asynchronous
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_R,
  input wire logic AUX_IN,
  input wire logic SUPPLY_FAULT,
  // function model select
  input wire logic [7:0] FUNC_MODEL,
  // register port
  input wire logic REG_WR,
  input wire logic [15:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // cyclic exchange
  input wire logic CYC_MODE_WR,
  input wire logic [7:0] CYC_MODE,
  output var quadrature_counter_homing_pkg::cyc_obj_t CYC_OBJ,
  // warning
  output logic SUPPLY_WARN
);
  logic [quadrature_counter_homing_pkg::IN_W-1:0] s1_q;
  logic [quadrature_counter_homing_pkg::IN_W-1:0] s2_q;
  logic [2:0] prev_q;
  logic [31:0] count_q;
  logic [31:0] preset1_q;
  logic [31:0] preset2_q;
  logic [15:0] edge_word_q;
  logic [7:0] fall_code_q;
  logic [7:0] rise_code_q;
  logic [7:0] ref_switch_q;
  logic [7:0] ref_level_q;
  logic [7:0] mode_q;
  logic [7:0] status_q;
  quadrature_counter_homing_pkg::home_state_t state_q;
  quadrature_counter_homing_pkg::home_state_t state_d;
  logic a_s;
  logic b_s;
  logic r_s;
  logic aux_s;
  logic step;
  logic up;
  logic ref_rise;
  logic ref_fall;
  logic pulse_ev;
  logic gate_ok;
  logic home_ev;
  logic mode_wr;
  logic [7:0] mode_wdata;
  logic mode_valid;
  logic wide;
  logic motion;
  logic [31:0] home_val;
  logic [31:0] count_view;
  logic [31:0] wdata_ext;
  logic [7:0] inlev;
  logic [7:0] supply;
  logic [31:0] rdata_d;

  // two flip-flops per pin before any use
  genvar gi;
  generate
    for (gi = 0; gi < quadrature_counter_homing_pkg::IN_W; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= (gi == quadrature_counter_homing_pkg::IN_A) ? ENC_A :
                      (gi == quadrature_counter_homing_pkg::IN_B) ? ENC_B :
                      (gi == quadrature_counter_homing_pkg::IN_R) ? ENC_R :
                      (gi == quadrature_counter_homing_pkg::IN_AUX) ? AUX_IN : SUPPLY_FAULT;
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  assign a_s = s2_q[quadrature_counter_homing_pkg::IN_A];
  assign b_s = s2_q[quadrature_counter_homing_pkg::IN_B];
  assign r_s = s2_q[quadrature_counter_homing_pkg::IN_R];
  assign aux_s = s2_q[quadrature_counter_homing_pkg::IN_AUX];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= {r_s, b_s, a_s};
    end
  end

  // a change on both channels at once is a lost step and is not counted
  assign step = (a_s ^ prev_q[0]) ^ (b_s ^ prev_q[1]);
  assign up = a_s ^ prev_q[1];

  assign ref_rise = r_s & ~prev_q[2];
  assign ref_fall = ~r_s & prev_q[2];
  // the rising code alone picks the edge; the other codes travel with it
  assign pulse_ev = (rise_code_q == quadrature_counter_homing_pkg::CODE_SEL) ? ref_rise : ref_fall;
  assign gate_ok = (ref_switch_q != quadrature_counter_homing_pkg::REF_ON) ||
                   (aux_s == (ref_level_q == quadrature_counter_homing_pkg::REF_ON));
  assign home_ev = pulse_ev & gate_ok & (state_q == quadrature_counter_homing_pkg::HS_ARMED);

  assign wide = (FUNC_MODEL == quadrature_counter_homing_pkg::FM_STD32);
  assign motion = (FUNC_MODEL == quadrature_counter_homing_pkg::FM_MOTION);
  assign wdata_ext = wide ? REG_WDATA : {{16{REG_WDATA[15]}}, REG_WDATA[15:0]};
  // single shot takes the first preset, continuous the second; the motion model takes zero
  assign home_val = motion ? 32'h0000_0000 :
                    (mode_q == quadrature_counter_homing_pkg::MODE_CONT) ? preset2_q : preset1_q;
  assign count_view = wide ? count_q : {{16{count_q[15]}}, count_q[15:0]};

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_q <= 32'h0000_0000;
    end else if (home_ev) begin
      count_q <= home_val;
    end else if (step) begin
      count_q <= up ? count_q + 32'h0000_0001 : count_q - 32'h0000_0001;
    end
  end

  // configuration registers, reached by acyclic writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      edge_word_q <= quadrature_counter_homing_pkg::EDGE_WORD_FALL;
      fall_code_q <= quadrature_counter_homing_pkg::CODE_SEL;
      rise_code_q <= quadrature_counter_homing_pkg::CODE_OFF;
      ref_switch_q <= quadrature_counter_homing_pkg::REF_OFF;
      ref_level_q <= quadrature_counter_homing_pkg::REF_OFF;
    end else if (REG_WR) begin
      case (REG_ADDR)
        quadrature_counter_homing_pkg::OFS_EDGE_WORD: edge_word_q <= REG_WDATA[15:0];
        quadrature_counter_homing_pkg::OFS_FALL_CODE: fall_code_q <= REG_WDATA[7:0];
        quadrature_counter_homing_pkg::OFS_RISE_CODE: rise_code_q <= REG_WDATA[7:0];
        quadrature_counter_homing_pkg::OFS_REF_SWITCH: ref_switch_q <= REG_WDATA[7:0];
        quadrature_counter_homing_pkg::OFS_REF_LEVEL: ref_level_q <= REG_WDATA[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      preset1_q <= 32'h0000_0000;
      preset2_q <= 32'h0000_0000;
    end else if (REG_WR && !motion) begin
      if (REG_ADDR == quadrature_counter_homing_pkg::OFS_PRESET_1) begin
        preset1_q <= wdata_ext;
      end
      if (REG_ADDR == quadrature_counter_homing_pkg::OFS_PRESET_2) begin
        preset2_q <= wdata_ext;
      end
    end
  end

  // mode arrives cyclically or at its register; undefined codes are ignored
  assign mode_wr = CYC_MODE_WR | (REG_WR && (REG_ADDR == quadrature_counter_homing_pkg::OFS_MODE));
  assign mode_wdata = CYC_MODE_WR ? CYC_MODE : REG_WDATA[7:0];
  assign mode_valid = (mode_wdata == quadrature_counter_homing_pkg::MODE_OFF) ||
                      (mode_wdata == quadrature_counter_homing_pkg::MODE_SINGLE) ||
                      (mode_wdata == quadrature_counter_homing_pkg::MODE_CONT);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= quadrature_counter_homing_pkg::MODE_OFF;
    end else if (mode_wr && mode_valid) begin
      mode_q <= mode_wdata;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      quadrature_counter_homing_pkg::HS_IDLE: begin
        if (mode_wr && mode_valid && mode_wdata != quadrature_counter_homing_pkg::MODE_OFF) begin
          state_d = quadrature_counter_homing_pkg::HS_ARMED;
        end
      end
      quadrature_counter_homing_pkg::HS_ARMED: begin
        if (home_ev && mode_q == quadrature_counter_homing_pkg::MODE_SINGLE) begin
          state_d = quadrature_counter_homing_pkg::HS_DONE;
        end
      end
      quadrature_counter_homing_pkg::HS_DONE: state_d = state_q;
      default: state_d = quadrature_counter_homing_pkg::HS_IDLE;
    endcase
    // a restart needs the mode written back to off first
    if (mode_wr && mode_wdata == quadrature_counter_homing_pkg::MODE_OFF) begin
      state_d = quadrature_counter_homing_pkg::HS_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= quadrature_counter_homing_pkg::HS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // homing status; a homing in the cycle of the clear still shows
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_q <= 8'h00;
    end else begin
      if (mode_wr && mode_wdata == quadrature_counter_homing_pkg::MODE_OFF) begin
        status_q[quadrature_counter_homing_pkg::ST_TOGGLE:quadrature_counter_homing_pkg::ST_HOMED] <= 2'h0;
      end
      if (home_ev) begin
        status_q[quadrature_counter_homing_pkg::ST_HOMED] <= 1'b1;
        status_q[quadrature_counter_homing_pkg::ST_TOGGLE] <= ~status_q[quadrature_counter_homing_pkg::ST_TOGGLE];
      end
      if (pulse_ev) begin
        status_q[quadrature_counter_homing_pkg::ST_REFSEEN] <= 1'b1;
        status_q[7:quadrature_counter_homing_pkg::ST_CNT_LO] <=
          status_q[7:quadrature_counter_homing_pkg::ST_CNT_LO] + 3'h1;
      end
    end
  end

  assign inlev = {4'h0, s2_q[quadrature_counter_homing_pkg::IN_AUX:quadrature_counter_homing_pkg::IN_A]};
  assign supply = {7'h00, s2_q[quadrature_counter_homing_pkg::IN_SUP]};

  // write-only registers read back as zero
  always_comb begin
    case (REG_ADDR)
      quadrature_counter_homing_pkg::OFS_SUPPLY: rdata_d = {24'h000000, supply};
      quadrature_counter_homing_pkg::OFS_INLEV: rdata_d = {24'h000000, inlev};
      quadrature_counter_homing_pkg::OFS_COUNT: rdata_d = count_view;
      quadrature_counter_homing_pkg::OFS_STATUS: rdata_d = {24'h000000, status_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 32'h0000_0000;
      CYC_OBJ <= '0;
      SUPPLY_WARN <= 1'b0;
    end else begin
      REG_RDATA <= rdata_d;
      CYC_OBJ.position_count <= count_q[15:0];
      CYC_OBJ.input_levels <= inlev;
      CYC_OBJ.supply_status <= supply;
      CYC_OBJ.homing_status <= status_q;
      SUPPLY_WARN <= s2_q[quadrature_counter_homing_pkg::IN_SUP];
    end
  end

  // checks
  sequence seq_single_home;
    home_ev && mode_q == quadrature_counter_homing_pkg::MODE_SINGLE;
  endsequence
  sequence seq_no_mode_write;
    !mode_wr;
  endsequence

  chk_count_step: assert property (@(posedge CLK) disable iff (!RESETN)
    step && !home_ev |=> count_q == $past(count_q) + ($past(up) ? 32'h1 : 32'hFFFF_FFFF))
    else $error("count step wrong");
  chk_home_load: assert property (@(posedge CLK) disable iff (!RESETN)
    home_ev |=> count_q == $past(home_val))
    else $error("home value not loaded");
  chk_warn_follow: assert property (@(posedge CLK) disable iff (!RESETN)
    SUPPLY_FAULT [*3] |=> SUPPLY_WARN)
    else $error("supply warning missing");
  chk_single_stop: assert property (@(posedge CLK) disable iff (!RESETN)
    seq_single_home ##1 seq_no_mode_write [*2] |-> !home_ev)
    else $error("single shot homed twice");
  chk_cont_reload: assert property (@(posedge CLK) disable iff (!RESETN)
    pulse_ev && gate_ok && state_q == quadrature_counter_homing_pkg::HS_ARMED &&
    mode_q == quadrature_counter_homing_pkg::MODE_CONT |=> count_q == $past(preset2_q) || $past(motion))
    else $error("continuous reload missing");
  chk_pulse_count: assert property (@(posedge CLK) disable iff (!RESETN)
    pulse_ev |=> status_q[7:5] == $past(status_q[7:5]) + 3'h1)
    else $error("index counter not advanced");
  chk_toggle_bit: assert property (@(posedge CLK) disable iff (!RESETN)
    home_ev |=> status_q[quadrature_counter_homing_pkg::ST_TOGGLE] != $past(status_q[quadrature_counter_homing_pkg::ST_TOGGLE])
    && status_q[quadrature_counter_homing_pkg::ST_HOMED])
    else $error("homing toggle wrong");
  chk_gate_block: assert property (@(posedge CLK) disable iff (!RESETN)
    ref_switch_q == quadrature_counter_homing_pkg::REF_ON && aux_s != ref_level_q[3] |-> !home_ev)
    else $error("homing not gated");
  chk_motion_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    motion && home_ev |=> count_q == 32'h0)
    else $error("motion preset not zero");
  chk_edge_default: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(RESETN) |-> fall_code_q == quadrature_counter_homing_pkg::CODE_SEL &&
    rise_code_q == quadrature_counter_homing_pkg::CODE_OFF &&
    edge_word_q == quadrature_counter_homing_pkg::EDGE_WORD_FALL)
    else $error("edge defaults wrong");
endmodule : quadrature_counter_homing
`default_nettype wire

// File: verif/quad_encoder_model.sv
// behavioural quadrature encoder with index pulse
`timescale 1ns/1ns
`default_nettype none
module quad_encoder_model (
  // clock
  input wire logic CLK,
  // encoder lines
  output logic ENC_A,
  output logic ENC_B,
  output logic ENC_R
);
  logic [1:0] phase = 2'b00;
  logic ref_lvl = 1'b0;
  // gray sequence: counting up lets A lead B
  assign ENC_A = phase[0] ^ phase[1];
  assign ENC_B = phase[1];
  assign ENC_R = ref_lvl;
  // each level is held long enough to cross the input synchroniser
  task automatic step(input logic up);
    @(negedge CLK);
    phase = up ? phase + 2'd1 : phase - 2'd1;
    repeat (4) @(negedge CLK);
  endtask : step
  task automatic index_pulse;
    @(negedge CLK);
    ref_lvl = 1'b1;
    repeat (6) @(negedge CLK);
    ref_lvl = 1'b0;
    repeat (8) @(negedge CLK);
  endtask : index_pulse
endmodule : quad_encoder_model
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the quadrature counter with homing
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {int kind; logic [39:0] val; logic [39:0] mask;} note_t;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic AUX_IN = 1'b0;
  logic SUPPLY_FAULT = 1'b0;
  logic [7:0] FUNC_MODEL = 8'h00;
  logic REG_WR = 1'b0;
  logic [15:0] REG_ADDR = 16'h0000;
  logic [31:0] REG_WDATA = 32'h00000000;
  logic CYC_MODE_WR = 1'b0;
  logic [7:0] CYC_MODE = 8'h00;
  logic [31:0] REG_RDATA;
  logic SUPPLY_WARN;
  quadrature_counter_homing_pkg::cyc_obj_t CYC_OBJ;
  wire logic ENC_A;
  wire logic ENC_B;
  wire logic ENC_R;
  note_t notes[$];
  note_t nt;
  int errors = 0;
  int checks = 0;
  int seed = 83;
  logic look = 1'b0;
  logic [31:0] exp_cnt = 32'h00000000;
  logic [31:0] pre;
  logic [31:0] n;
  logic [2:0] cnt = 3'h0;
  logic tog = 1'b0;
  // gating table per pulse: aux level, switch on, active-high level, steps before
  logic [5:0] aux_t = 6'b100100;
  logic [5:0] sw_t = 6'b111100;
  logic [5:0] lvl_t = 6'b110000;
  int steps_t[6] = '{0, 3, 2, 0, 1, 0};

  always #5 CLK = ~CLK;

  quadrature_counter_homing u_quadrature_counter_homing (.CLK(CLK), .RESETN(RESETN), .ENC_A(ENC_A),
    .ENC_B(ENC_B), .ENC_R(ENC_R), .AUX_IN(AUX_IN), .SUPPLY_FAULT(SUPPLY_FAULT), .FUNC_MODEL(FUNC_MODEL),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CYC_MODE_WR(CYC_MODE_WR), .CYC_MODE(CYC_MODE), .CYC_OBJ(CYC_OBJ), .SUPPLY_WARN(SUPPLY_WARN));
  quad_encoder_model u_quad_encoder_model (.CLK(CLK), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_R(ENC_R));

  task automatic give_verdict;
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_cyc(input logic [39:0] got, input logic [39:0] exp, input logic [39:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("[FAIL] %0t cyclic object %h expected %h", $time, got, exp);
    end
  endtask : cmp_cyc
  task automatic cmp_warn(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t supply warning %b expected %b", $time, got, exp);
    end
  endtask : cmp_warn
  // note an expectation; the read address is held for the one cycle the answer needs
  task automatic expect_out(input int k, input logic [15:0] a, input logic [39:0] v, input logic [39:0] m);
    @(negedge CLK);
    REG_ADDR = a;
    notes.push_back('{k, v, m});
    look = 1'b1;
    @(negedge CLK);
    look = 1'b0;
  endtask : expect_out
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask : wr
  task automatic set_mode(input logic [7:0] m);
    @(negedge CLK);
    CYC_MODE_WR = 1'b1;
    CYC_MODE = m;
    @(negedge CLK);
    CYC_MODE_WR = 1'b0;
  endtask : set_mode

  // watcher: registered outputs are settled just after the edge
  always @(posedge CLK) begin
    if (look) begin
      #1;
      nt = notes.pop_front();
      case (nt.kind)
        0: cmp_reg(REG_RDATA, nt.val[31:0], nt.mask[31:0]);
        1: cmp_cyc(CYC_OBJ, nt.val, nt.mask);
        default: cmp_warn(SUPPLY_WARN, nt.val[0]);
      endcase
    end
  end

  initial begin
    for (int i = 0; i < 20000; i++) @(posedge CLK);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    RESETN = 1'b1;
    expect_out(0, quadrature_counter_homing_pkg::OFS_STATUS, 40'h0, 40'hFF);
    expect_out(0, quadrature_counter_homing_pkg::OFS_EDGE_WORD, 40'h0, 40'hFFFFFFFF);
    expect_out(0, 16'h0002, 40'h0, 40'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      n = $random(seed);
      AUX_IN = n[0];
      SUPPLY_FAULT = n[1];
      u_quad_encoder_model.step(n[2]);
      exp_cnt = n[2] ? exp_cnt + 32'h1 : exp_cnt - 32'h1;
      expect_out(0, quadrature_counter_homing_pkg::OFS_COUNT, {8'h0, exp_cnt}, 40'hFFFF);
      expect_out(0, quadrature_counter_homing_pkg::OFS_INLEV, {36'h0, AUX_IN, ENC_R, ENC_B, ENC_A}, 40'hFF);
      expect_out(0, quadrature_counter_homing_pkg::OFS_SUPPLY, {39'h0, SUPPLY_FAULT}, 40'hFF);
      expect_out(2, REG_ADDR, {39'h0, SUPPLY_FAULT}, 40'h1);
      expect_out(1, REG_ADDR, {15'h0, SUPPLY_FAULT, 4'h0, AUX_IN, ENC_R, ENC_B, ENC_A, exp_cnt[15:0]},
        40'hFFFFFFFFFF);
    end
    pre = $random(seed);
    wr(quadrature_counter_homing_pkg::OFS_PRESET_1, pre);
    set_mode(quadrature_counter_homing_pkg::MODE_SINGLE);
    u_quad_encoder_model.index_pulse();
    exp_cnt = {{16{pre[15]}}, pre[15:0]};
    expect_out(0, quadrature_counter_homing_pkg::OFS_COUNT, {8'h0, exp_cnt}, 40'hFFFF);
    expect_out(0, quadrature_counter_homing_pkg::OFS_STATUS, 40'h3C, 40'hFF);
    // a spent single shot only counts the pulse
    u_quad_encoder_model.index_pulse();
    expect_out(0, quadrature_counter_homing_pkg::OFS_STATUS, 40'h5C, 40'hFF);
    set_mode(quadrature_counter_homing_pkg::MODE_OFF);
    expect_out(0, quadrature_counter_homing_pkg::OFS_STATUS, 40'h50, 40'hFF);
    wr(quadrature_counter_homing_pkg::OFS_FALL_CODE, {24'h0, quadrature_counter_homing_pkg::CODE_OFF});
    wr(quadrature_counter_homing_pkg::OFS_RISE_CODE, {24'h0, quadrature_counter_homing_pkg::CODE_SEL});
    wr(quadrature_counter_homing_pkg::OFS_EDGE_WORD, {16'h0, quadrature_counter_homing_pkg::EDGE_WORD_RISE});
    pre = $random(seed);
    wr(quadrature_counter_homing_pkg::OFS_PRESET_2, pre);
    set_mode(quadrature_counter_homing_pkg::MODE_CONT);
    cnt = 3'h2;
    for (int k = 0; k < 6; k++) begin
      wr(quadrature_counter_homing_pkg::OFS_REF_SWITCH, sw_t[k] ? 32'h08 : 32'h00);
      wr(quadrature_counter_homing_pkg::OFS_REF_LEVEL, lvl_t[k] ? 32'h08 : 32'h00);
      AUX_IN = aux_t[k];
      for (int s = 0; s < steps_t[k]; s++) begin
        u_quad_encoder_model.step(1'b1);
        exp_cnt = exp_cnt + 32'h1;
      end
      u_quad_encoder_model.index_pulse();
      cnt = cnt + 3'h1;
      if (!sw_t[k] || aux_t[k] == lvl_t[k]) begin
        exp_cnt = {{16{pre[15]}}, pre[15:0]};
        tog = ~tog;
      end
      expect_out(0, quadrature_counter_homing_pkg::OFS_COUNT, {8'h0, exp_cnt}, 40'hFFFF);
      expect_out(0, quadrature_counter_homing_pkg::OFS_STATUS, {32'h0, cnt, 1'b1, tog, 3'b100}, 40'hFF);
    end
    // wide count, then the model that homes to zero whatever the presets hold
    for (int k = 1; k < 3; k++) begin
      FUNC_MODEL = k[7:0];
      pre = $random(seed);
      wr(quadrature_counter_homing_pkg::OFS_PRESET_1, pre);
      // the mode register path is used here so that it is exercised too
      wr(quadrature_counter_homing_pkg::OFS_MODE, {24'h0, quadrature_counter_homing_pkg::MODE_OFF});
      set_mode(quadrature_counter_homing_pkg::MODE_SINGLE);
      u_quad_encoder_model.index_pulse();
      expect_out(0, quadrature_counter_homing_pkg::OFS_COUNT, (k == 2) ? 40'h0 : {8'h0, pre}, 40'hFFFFFFFF);
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
